// File: hdl/cmd_defines.svh
// constants for the host packet command interpreter
`ifndef CMD_DEFINES_SVH
`define CMD_DEFINES_SVH

// =====================================================================
// timing
`define CLK_PERIOD_NS 25
`define FLASH_TIME_MS 1000
`define BLINK_TIME_MS 50
`define FLASH_CYCLES ((`FLASH_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define BLINK_CYCLES ((`BLINK_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define STROBE_CYCLES 4

// =====================================================================
// packet layout and codes
`define PKT_MAX 5
`define PKT_MIN_LEN 8'h02
`define NUM_PINS 42
`define CMD_PING 8'h27
`define CMD_FLASH 8'h28
`define CMD_LED 8'h29
`define CMD_PIN 8'h30
`define PING_REPLY 8'h50
`define ERR_CMD 8'hE0
`define ERR_PIN 8'hE1
`define ERR_WO_READ 8'hE3
`define DIR_WRITE 8'h00
`define LVL_HIGH 8'h01
`define PIN_WO_A 8'hF6
`define PIN_WO_B 8'hF7
`define PIN_WO_A_IDX 6'h28
`define PIN_WO_B_IDX 6'h29

`endif

// File: hdl/cmd_pkg.sv
// types shared by the host packet command interpreter
package cmd_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RD = 3'b001,
    S_GAP = 3'b010,
    S_EXEC = 3'b011,
    S_TXW = 3'b100,
    S_WR = 3'b101
  } state_e;
  typedef logic [7:0] byte_t;
endpackage : cmd_pkg

// File: hdl/host_packet_command_interpreter.sv
// byte-packet command interpreter behind a parallel fifo bridge channel
// Operation
// RL1 - packet byte0 is total length, byte1 command; collect all bytes first
// RL2 - ping (len 2, code 0x27) replies single byte 0x50
// RL3 - flash code 0x28 blinks led about one second, echoes 0x28
// RL4 - led packet len 3, code 0x29; byte2 0x00 off, 0x01 on
// RL5 - led packet reply is exactly one byte 0x29
// RL6 - host sends pin packet length 4 for read, 5 for write
// RL7 - pin packet byte2 selects pin, code 0x00 to 0xF7
// RL8 - byte3 0x00 writes and makes output; 0x01 reads and makes input
// RL9 - pin read first reply byte is level, 0x00 low, 0x01 high
// RL10 - pin read second reply byte is echo 0x30
// RL11 - pin write byte4 drives selected pin low 0x00, high 0x01
// RL12 - pin write reply is exactly one byte 0x30
// RL13 - commands pass over the parallel fifo channel
// RL14 - second channel is a separate uart link
// RL15 - unsupported command replies 0xE0, no action
// RL16 - invalid pin number replies 0xE1
// RL17 - read of either write-only pin replies 0xE3
// RL18 - valid pins: 0x00-07,20-27,30-37,40-47,C0-C7, F6, F7
// RL19 - one packet at a time, reply finished before next length byte
`timescale 1ns/1ps
`include "cmd_defines.svh"

module host_packet_command_interpreter #(
  parameter int FLASH_CYCLES = `FLASH_CYCLES, // led flash length
  parameter int BLINK_CYCLES = `BLINK_CYCLES, // half period of the blink
  parameter int NPIN = `NUM_PINS // user pins
) (
  input wire logic mclk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic rxf_n, // bridge holds a byte, active low
  output logic rd_n, // read strobe to bridge, active low
  input wire logic txe_n, // bridge can take a byte, active low
  output logic wr_n, // write strobe to bridge, active low
  input wire logic [7:0] fifo_data_i, // bridge data bus in
  output logic [7:0] fifo_data_o, // bridge data bus out
  output logic fifo_data_oe_n, // bus drive enable, low drives
  input wire logic uart_rx, // serial link from bridge
  output logic uart_tx, // serial link to bridge
  output logic led, // status led, high lit
  input wire logic [NPIN-1:0] pin_in, // user pin levels
  output logic [NPIN-1:0] pin_out, // user pin drive levels
  output logic [NPIN-1:0] pin_oe_n // user pin enables, low drives
);
  import cmd_pkg::*;

  // =====================================================================
  // synchronisers
  logic rxf_m_q, rxf_n_q, txe_m_q, txe_n_q, uart_m_q, uart_s_q;
  byte_t data_m_q, data_s_q;
  logic [NPIN-1:0] pin_m_q, pin_s_q;

  // every pin-side input takes two flops before use
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {rxf_m_q, rxf_n_q, txe_m_q, txe_n_q, uart_m_q, uart_s_q} <= 6'h3F;
      data_m_q <= 8'h00;
      data_s_q <= 8'h00;
      pin_m_q <= '0;
      pin_s_q <= '0;
    end else begin
      {rxf_m_q, rxf_n_q} <= {rxf_n, rxf_m_q};
      {txe_m_q, txe_n_q} <= {txe_n, txe_m_q};
      {uart_m_q, uart_s_q} <= {uart_rx, uart_m_q};
      {data_m_q, data_s_q} <= {fifo_data_i, data_m_q};
      {pin_m_q, pin_s_q} <= {pin_in, pin_m_q};
    end
  end

  // =====================================================================
  // packet decode
  state_e state_q;
  byte_t pkt_q [0:`PKT_MAX-1];
  byte_t cnt_q, rep0_q, rep1_q, rep0_d;
  logic [2:0] tmr_q;
  logic pend_q, two_q, two_d;
  logic led_state_q, flash_q, blink_q, led_q, uart_tx_q;
  logic [31:0] flash_cnt_q, blink_cnt_q;
  logic [NPIN-1:0] pin_out_q, pin_oe_n_q;

  wire byte_t cmd = pkt_q[1];
  wire byte_t pcode = pkt_q[2];
  wire byte_t need = (pkt_q[0] < `PKT_MIN_LEN) ? `PKT_MIN_LEN : pkt_q[0];
  wire last_byte = (cnt_q != 8'h00) && (cnt_q + 8'h01 >= need); // RL1
  wire strobe_end = tmr_q == 3'(`STROBE_CYCLES - 1);
  // pin groups map to index blocks of eight
  wire grp_ok = pcode[7:4] == 4'h0 || pcode[7:4] == 4'h2 || pcode[7:4] == 4'h3 ||
    pcode[7:4] == 4'h4 || pcode[7:4] == 4'hC; // RL18
  wire [2:0] grp = (pcode[7:4] == 4'h0) ? 3'h0 : (pcode[7:4] == 4'h2) ? 3'h1 :
    (pcode[7:4] == 4'h3) ? 3'h2 : (pcode[7:4] == 4'h4) ? 3'h3 : 3'h4;
  wire pin_wo = pcode == `PIN_WO_A || pcode == `PIN_WO_B; // RL17
  wire pin_ok = pin_wo || (grp_ok && !pcode[3]); // RL7
  wire [5:0] pin_idx = pin_wo ? (pcode[0] ? `PIN_WO_B_IDX : `PIN_WO_A_IDX) :
    {grp, pcode[2:0]};
  wire pin_rd = pkt_q[3] != `DIR_WRITE; // RL8
  wire pin_lvl = pin_s_q[pin_idx];
  wire exec = state_q == S_EXEC;

  // reply selection; any direction code other than write is taken as read
  always_comb begin
    rep0_d = `ERR_CMD; // RL15
    two_d = 1'b0;
    if (cmd == `CMD_PING) begin
      rep0_d = `PING_REPLY; // RL2
    end else if (cmd == `CMD_FLASH || cmd == `CMD_LED) begin
      rep0_d = cmd; // RL3 RL5
    end else if (cmd == `CMD_PIN) begin
      if (!pin_ok) begin
        rep0_d = `ERR_PIN; // RL16
      end else if (pin_rd && pin_wo) begin
        rep0_d = `ERR_WO_READ; // RL17
      end else if (pin_rd) begin
        rep0_d = {7'h00, pin_lvl}; // RL9
        two_d = 1'b1; // RL10
      end else begin
        rep0_d = cmd; // RL12
      end
    end
  end

  // =====================================================================
  // fifo handshake and packet sequencing
  // gap after each write strobe and every read strobe but a packet's last outlasts the flag synchronisers, so stale flags are never used
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      tmr_q <= 3'h0;
      cnt_q <= 8'h00;
      pend_q <= 1'b0;
      two_q <= 1'b0;
      rep0_q <= 8'h00;
      rep1_q <= 8'h00;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      fifo_data_o <= 8'h00;
      fifo_data_oe_n <= 1'b1;
      for (int i = 0; i < `PKT_MAX; i++) pkt_q[i] <= 8'h00;
    end else begin
      case (state_q)
        S_IDLE: begin
          tmr_q <= 3'h0;
          if (!rxf_n_q) begin
            rd_n <= 1'b0; // RL13
            state_q <= S_RD;
          end
        end
        S_RD: begin
          tmr_q <= tmr_q + 3'h1;
          if (strobe_end) begin
            if (cnt_q < 8'(`PKT_MAX)) pkt_q[cnt_q[2:0]] <= data_s_q; // RL1
            cnt_q <= cnt_q + 8'h01;
            rd_n <= 1'b1;
            tmr_q <= 3'h0;
            state_q <= last_byte ? S_EXEC : S_GAP; // RL19
          end
        end
        S_GAP: begin
          tmr_q <= tmr_q + 3'h1;
          if (strobe_end) begin
            fifo_data_oe_n <= 1'b1;
            pend_q <= 1'b0;
            state_q <= pend_q ? S_TXW : S_IDLE;
          end
        end
        S_EXEC: begin
          rep0_q <= rep0_d;
          rep1_q <= `CMD_PIN;
          two_q <= two_d;
          cnt_q <= 8'h00;
          state_q <= S_TXW;
        end
        S_TXW: begin
          tmr_q <= 3'h0;
          if (!txe_n_q) begin
            fifo_data_o <= rep0_q;
            fifo_data_oe_n <= 1'b0;
            state_q <= S_WR;
          end
        end
        S_WR: begin
          wr_n <= strobe_end;
          tmr_q <= tmr_q + 3'h1;
          if (strobe_end) begin
            tmr_q <= 3'h0;
            pend_q <= two_q; // second reply byte pending
            two_q <= 1'b0;
            rep0_q <= rep1_q; // RL10
            state_q <= S_GAP;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // =====================================================================
  // command actions: led, flash timer, user pins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      led_state_q <= 1'b0;
      pin_out_q <= '0;
      pin_oe_n_q <= '1;
    end else if (exec && cmd == `CMD_LED) begin
      led_state_q <= pkt_q[2] == `LVL_HIGH; // RL4
    end else if (exec && cmd == `CMD_PIN && pin_ok && !(pin_rd && pin_wo)) begin
      pin_oe_n_q[pin_idx] <= pin_rd; // RL8
      if (!pin_rd) pin_out_q[pin_idx] <= pkt_q[4] == `LVL_HIGH; // RL11
    end
  end

  // flash runs in the background so the echo is not held for a second
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flash_q <= 1'b0;
      blink_q <= 1'b0;
      flash_cnt_q <= 32'h0;
      blink_cnt_q <= 32'h0;
    end else if (exec && cmd == `CMD_FLASH) begin
      flash_q <= 1'b1; // RL3
      blink_q <= 1'b1;
      flash_cnt_q <= 32'h0;
      blink_cnt_q <= 32'h0;
    end else if (flash_q) begin
      flash_cnt_q <= flash_cnt_q + 32'h1;
      blink_cnt_q <= (blink_cnt_q == 32'(BLINK_CYCLES - 1)) ? 32'h0 : blink_cnt_q + 32'h1;
      if (blink_cnt_q == 32'(BLINK_CYCLES - 1)) blink_q <= !blink_q;
      if (flash_cnt_q == 32'(FLASH_CYCLES - 1)) flash_q <= 1'b0;
    end
  end

  // serial channel is looped back, kept apart from the packet path
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      led_q <= 1'b0;
      uart_tx_q <= 1'b1;
    end else begin
      led_q <= flash_q ? blink_q : led_state_q;
      uart_tx_q <= uart_s_q; // RL14
    end
  end

  assign led = led_q;
  assign uart_tx = uart_tx_q;
  assign pin_out = pin_out_q;
  assign pin_oe_n = pin_oe_n_q;

  // =====================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  chk_ping_reply: assert property (exec && cmd == `CMD_PING |=> rep0_q == `PING_REPLY && !two_q) // RL2
    else $error("ping reply wrong");
  chk_flash_start: assert property (exec && cmd == `CMD_FLASH |=> flash_q && rep0_q == `CMD_FLASH) // RL3
    else $error("flash not started or echo wrong");
  chk_led_set: assert property (exec && cmd == `CMD_LED |=> led_state_q == $past(pkt_q[2] == `LVL_HIGH)) // RL4
    else $error("led state not applied");
  chk_led_echo: assert property (exec && cmd == `CMD_LED |=> rep0_q == `CMD_LED && !two_q) // RL5
    else $error("led echo wrong");
  chk_read_pair: assert property (exec && cmd == `CMD_PIN && pin_ok && pin_rd && !pin_wo
    |=> two_q && rep1_q == `CMD_PIN && rep0_q == {7'h00, $past(pin_lvl)}) // RL9
    else $error("pin read reply wrong");
  chk_write_drive: assert property (exec && cmd == `CMD_PIN && pin_ok && !pin_rd
    |=> !pin_oe_n_q[$past(pin_idx)] && pin_out_q[$past(pin_idx)] == $past(pkt_q[4][0])) // RL11
    else $error("pin write not driven");
  chk_bad_cmd: assert property (exec && !(cmd inside {`CMD_PING, `CMD_FLASH, `CMD_LED, `CMD_PIN})
    |=> rep0_q == `ERR_CMD && $stable(pin_oe_n_q)) // RL15
    else $error("bad command not rejected");
  chk_bad_pin: assert property (exec && cmd == `CMD_PIN && !pin_ok |=> rep0_q == `ERR_PIN) // RL16
    else $error("bad pin not rejected");
  chk_wo_read: assert property (exec && cmd == `CMD_PIN && pin_wo && pin_rd
    |=> rep0_q == `ERR_WO_READ && !two_q) // RL17
    else $error("write-only read not rejected");
  chk_one_packet: assert property (state_q inside {S_EXEC, S_TXW, S_WR} |-> rd_n) // RL19
    else $error("read during reply");
endmodule : host_packet_command_interpreter

// File: testbench/bridge_model.sv
// bridge parallel fifo channel model: host bytes in, device replies out
`timescale 1ns/1ps
module bridge_model (
  input wire logic mclk, // system clock
  input wire logic rd_n, // device read strobe, active low
  input wire logic wr_n, // device write strobe, active low
  input wire logic [7:0] fifo_data_o, // device bus out
  input wire logic fifo_data_oe_n, // low while device drives bus
  input wire logic txe_stall, // high holds replies off
  output logic rxf_n, // host byte pending, active low
  output logic txe_n, // room for a reply, active low
  output logic [7:0] fifo_data_i // host byte on the bus
);
  import cmd_pkg::*;
  byte_t host_q[$]; // bytes not yet read by the device
  byte_t reply_q[$]; // bytes written by the device
  initial begin
    rxf_n = 1'b1;
    txe_n = 1'b1;
    fifo_data_i = 8'hA5;
  end
  // flags move on the falling edge so the device syncs a settled level
  always @(negedge mclk) begin
    rxf_n <= (host_q.size() == 0);
    txe_n <= txe_stall;
    // an idle bus is undriven, so show a changing pattern, not the old byte
    if (host_q.size() != 0) fifo_data_i <= host_q[0];
    else fifo_data_i <= ~fifo_data_i;
  end
  // a byte is used up when the device ends its read strobe
  always @(posedge rd_n) if (host_q.size() != 0) void'(host_q.pop_front());
  always @(posedge wr_n) if (fifo_data_oe_n == 1'b0) reply_q.push_back(fifo_data_o);
endmodule : bridge_model

// File: testbench/testbench.sv
// self-checking bench for the host packet command interpreter
`timescale 1ns/1ps
`include "cmd_defines.svh"
module testbench;
  import cmd_pkg::*;
  localparam int NP = `NUM_PINS;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic uart_rx = 1'b1;
  logic txe_stall = 1'b0;
  logic [NP-1:0] pin_in = '0;
  logic rxf_n, rd_n, txe_n, wr_n, fifo_data_oe_n, uart_tx, led;
  logic [7:0] fifo_data_i, fifo_data_o;
  logic [NP-1:0] pin_out, pin_oe_n;
  byte_t none[$];
  int errors = 0;
  int total_checks = 0;
  // ===================================================================
  // clock and instances
  always #12.5 mclk = ~mclk;
  // short flash counts keep the run brief
  host_packet_command_interpreter #(.FLASH_CYCLES(200), .BLINK_CYCLES(20))
    host_packet_command_interpreter_inst (.mclk, .resetn, .rxf_n, .rd_n, .txe_n, .wr_n,
    .fifo_data_i, .fifo_data_o, .fifo_data_oe_n, .uart_rx, .uart_tx, .led, .pin_in,
    .pin_out, .pin_oe_n);
  bridge_model bridge_model_inst (.mclk, .rd_n, .wr_n, .fifo_data_o, .fifo_data_oe_n,
    .txe_stall, .rxf_n, .txe_n, .fifo_data_i);
  // ===================================================================
  // shared tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // whole packet out, then the full reply and nothing after it
  task automatic xfer(input byte_t pkt[$], input byte_t exp[$]);
    int n;
    n = 0;
    bridge_model_inst.reply_q.delete();
    foreach (pkt[i]) bridge_model_inst.host_q.push_back(pkt[i]);
    while (bridge_model_inst.reply_q.size() < exp.size() && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    repeat (40) @(negedge mclk);
    chk(8'(bridge_model_inst.reply_q.size()), 8'(exp.size()), "reply count");
    if (n >= 3000) end_sim();
    foreach (exp[i]) begin
      if (i < bridge_model_inst.reply_q.size()) chk(bridge_model_inst.reply_q[i], exp[i], "byte");
    end
  endtask : xfer
  // ===================================================================
  // scenarios
  task automatic t_ping_uart();
    xfer({8'h02, `CMD_PING}, {`PING_REPLY});
    uart_rx = 1'b0;
    repeat (4) @(negedge mclk);
    chk(8'(uart_tx), 8'h00, "serial low");
    uart_rx = 1'b1;
    repeat (4) @(negedge mclk);
    chk(8'(uart_tx), 8'h01, "serial high");
    $display("ping and serial test done");
  endtask : t_ping_uart
  task automatic t_led();
    xfer({8'h03, `CMD_LED, 8'h01}, {`CMD_LED});
    chk(8'(led), 8'h01, "led on");
    xfer({8'h03, `CMD_LED, 8'h00}, {`CMD_LED});
    chk(8'(led), 8'h00, "led off");
    $display("led test done");
  endtask : t_led
  task automatic t_flash();
    int lit;
    int dark;
    lit = 0;
    dark = 0;
    xfer({8'h02, `CMD_FLASH}, {`CMD_FLASH});
    // a blink needs both levels inside the window, a stuck led shows only one
    repeat (60) begin
      @(negedge mclk);
      if (led === 1'b1) lit++;
      if (led === 1'b0) dark++;
    end
    chk(8'(lit > 0), 8'h01, "led blinks");
    chk(8'(dark > 0), 8'h01, "led goes dark");
    repeat (300) @(negedge mclk);
    chk(8'(led), 8'h00, "flash over");
    $display("flash test done");
  endtask : t_flash
  task automatic t_pin_write();
    for (int v = 1; v >= 0; v--) begin
      xfer({8'h05, `CMD_PIN, 8'h33, `DIR_WRITE, 8'(v)}, {`CMD_PIN});
      // code 0x33 is group three, bit three: index 2*8+3
      chk(8'(pin_oe_n[19]), 8'h00, "pin driven");
      chk(8'(pin_out[19]), 8'(v), "pin level");
    end
    xfer({8'h05, `CMD_PIN, `PIN_WO_B, `DIR_WRITE, 8'h01}, {`CMD_PIN});
    chk(8'(pin_oe_n[41]), 8'h00, "write only pin driven");
    chk(8'(pin_out[41]), 8'h01, "write only pin");
    $display("pin write test done");
  endtask : t_pin_write
  task automatic t_pin_read();
    byte_t good[$] = {8'h07, 8'h20, 8'h47, 8'hC0};
    for (int v = 0; v < 2; v++) begin
      pin_in[37] = v[0];
      xfer({8'h04, `CMD_PIN, 8'hC5, 8'h01}, {8'(v), `CMD_PIN});
    end
    pin_in[19] = 1'b1;
    xfer({8'h04, `CMD_PIN, 8'h33, 8'h01}, {8'h01, `CMD_PIN});
    chk(8'(pin_oe_n[19]), 8'h01, "pin released");
    foreach (good[i]) xfer({8'h04, `CMD_PIN, good[i], 8'h01}, {8'h00, `CMD_PIN});
    $display("pin read test done");
  endtask : t_pin_read
  task automatic t_errors();
    byte_t bad[$] = {8'h08, 8'h1F, 8'h50, 8'hBF, 8'hC8, 8'hF5};
    xfer({8'h03, 8'h2A, 8'h01}, {`ERR_CMD});
    chk(8'(led), 8'h00, "no action");
    foreach (bad[i]) xfer({8'h04, `CMD_PIN, bad[i], 8'h01}, {`ERR_PIN});
    xfer({8'h04, `CMD_PIN, `PIN_WO_A, 8'h01}, {`ERR_WO_READ});
    xfer({8'h04, `CMD_PIN, `PIN_WO_B, 8'h01}, {`ERR_WO_READ});
    $display("error reply test done");
  endtask : t_errors
  // a stalled reply must hold off reading the next packet
  task automatic t_order();
    txe_stall = 1'b1;
    bridge_model_inst.host_q = {8'h02, `CMD_PING, 8'h03, `CMD_LED, 8'h01};
    repeat (200) @(negedge mclk);
    chk(8'(bridge_model_inst.host_q.size()), 8'h03, "next packet held");
    txe_stall = 1'b0;
    xfer(none, {`PING_REPLY, `CMD_LED});
    chk(8'(led), 8'h01, "second packet");
    $display("order test done");
  endtask : t_order
  // ===================================================================
  // main sequence
  initial begin
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    repeat (2) @(negedge mclk);
    t_ping_uart();
    t_led();
    t_flash();
    t_pin_write();
    t_pin_read();
    t_errors();
    t_order();
    end_sim();
  end
endmodule : testbench
